//--- hdl/output_format.sv
// output data format register, serial config port and formatted sample path

////////////////////////////////////////////////////////////////////////////////
module sample_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [PW:0] count, next_count;
  logic push, pop;

  assign in_ready = (count != FULL_COUNT);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (ce) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage holds no reset; an entry is only read out at rd_ptr after it has been written
  always_ff @(posedge sys_clk) begin
    if (ce && push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module output_format (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  output logic sdo_o,
  output logic sdo_oe,
  input wire logic in_valid,
  output logic in_ready,
  input wire fmt_pkg::sample_s in_word,
  output logic out_valid,
  input wire logic out_ready,
  output fmt_pkg::sample_s out_word
);
  import fmt_pkg::*;

  typedef enum logic {PORT_IDLE, PORT_SHIFT} port_state_e;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] cs_sync, sck_sync, sdi_sync;
  logic sck_last;
  logic cs_n_s, sck_s, sdi_s, sck_rise, sck_fall;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cs_sync <= 2'h3;
      sck_sync <= 2'h0;
      sdi_sync <= 2'h0;
      sck_last <= 1'b0;
    end else if (ce) begin
      cs_sync <= {cs_sync[0], cs_n};
      sck_sync <= {sck_sync[0], sck};
      sdi_sync <= {sdi_sync[0], sdi};
      sck_last <= sck_sync[1];
    end
  end

  assign cs_n_s = cs_sync[1];
  assign sck_s = sck_sync[1];
  assign sdi_s = sdi_sync[1];
  assign sck_rise = sck_s && !sck_last;
  assign sck_fall = !sck_s && sck_last;

  //////////////////////////////////////////////////////////////////////////////
  // serial configuration port and format register
  port_state_e state, next_state;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [FRAME_BITS-2:0] frame, next_frame;
  logic [7:0] rd_data, next_rd_data;
  logic reading, next_reading;
  logic [7:0] format_reg, next_format_reg;
  logic [6:0] rd_addr;

  assign rd_addr = {frame[5:0], sdi_s};

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_frame = frame;
    next_rd_data = rd_data;
    next_reading = reading;
    next_format_reg = format_reg;
    case (state)
      PORT_IDLE: begin
        next_reading = 1'b0;
        if (!cs_n_s) begin
          next_state = PORT_SHIFT;
          next_bit_cnt = '0;
        end
      end
      PORT_SHIFT: begin
        if (cs_n_s) begin
          next_state = PORT_IDLE;
          next_reading = 1'b0;
        end else if (sck_rise && bit_cnt != FRAME_END) begin
          next_frame = {frame[FRAME_BITS-3:0], sdi_s};
          next_bit_cnt = bit_cnt + 1'b1;
          if (bit_cnt == ADDR_LAST && frame[6]) begin
            next_reading = 1'b1;
            next_rd_data = (rd_addr == FORMAT_OFFSET) ? (format_reg & FORMAT_USED_MASK) : 8'h00;
          end
          if (bit_cnt == FRAME_LAST && !frame[FRAME_BITS-2]) begin
            if (frame[13:7] == FORMAT_OFFSET) begin
              next_format_reg = {frame[6:0], sdi_s} & FORMAT_USED_MASK;
            end else if (frame[13:7] == RESET_OFFSET && frame[SOFT_RESET_BIT-1]) begin
              next_format_reg = FORMAT_RESET;
            end
          end
        end else if (sck_fall && reading && bit_cnt >= READ_SHIFT_FROM) begin
          // ones fill in behind the data so the line lets go after the last bit
          next_rd_data = {rd_data[6:0], 1'b1};
        end
      end
      default: begin
        next_state = PORT_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= PORT_IDLE;
      bit_cnt <= '0;
      frame <= '0;
      rd_data <= 8'h00;
      reading <= 1'b0;
      format_reg <= FORMAT_RESET;
    end else if (ce) begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      frame <= next_frame;
      rd_data <= next_rd_data;
      reading <= next_reading;
      format_reg <= next_format_reg;
    end
  end

  // open drain: only ever pulls low
  assign sdo_o = 1'b0;
  assign sdo_oe = reading && !rd_data[7];

  //////////////////////////////////////////////////////////////////////////////
  // sample path: fifo then formatting stage
  logic f_valid, f_pop;
  logic [WORD_W-1:0] f_data;

  sample_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) fifo_i (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_word),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  logic [2:0] pattern;
  logic alt_pol, scramble, signed_sel;
  logic phase, next_phase;
  logic out_valid_r, next_out_valid;
  logic [WORD_W-1:0] out_r, next_out;
  logic [WORD_W-1:0] shaped;

  assign pattern = format_reg[TEST_PATTERN_LSB +: 3];
  assign alt_pol = format_reg[ALT_POLARITY_BIT];
  assign scramble = format_reg[SCRAMBLE_BIT];
  assign signed_sel = format_reg[SIGNED_BIT];
  assign f_pop = f_valid && (!out_valid_r || out_ready);

  always_comb begin
    shaped = f_data;
    if (signed_sel && !alt_pol) begin
      shaped[SAMPLE_W-1] = ~f_data[SAMPLE_W-1];
    end
    if (scramble) begin
      shaped[SAMPLE_W-1:1] = shaped[SAMPLE_W-1:1] ^ {(SAMPLE_W-1){shaped[0]}};
    end
    if (alt_pol) begin
      shaped = shaped ^ ODD_BITS;
    end
  end

  always_comb begin
    next_phase = phase;
    next_out_valid = out_valid_r;
    next_out = out_r;
    if (out_valid_r && out_ready) begin
      next_out_valid = 1'b0;
    end
    if (f_pop) begin
      next_out_valid = 1'b1;
      next_phase = ~phase;
      case (pattern)
        TP_OFF: next_out = shaped;
        TP_ZEROS: next_out = '0;
        TP_ONES: next_out = '1;
        TP_CHECKER: next_out = phase ? CHECKER_B : CHECKER_A;
        TP_TOGGLE: next_out = phase ? '1 : '0;
        default: next_out = shaped;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase <= 1'b0;
      out_valid_r <= 1'b0;
      out_r <= '0;
    end else if (ce) begin
      phase <= next_phase;
      out_valid_r <= next_out_valid;
      out_r <= next_out;
    end
  end

  assign out_valid = out_valid_r;
  assign out_word = out_r;
endmodule

//--- inc/fmt_pkg.sv
// constants and types for the converter output data format block
package fmt_pkg;
  localparam int SAMPLE_W = 14;
  localparam int WORD_W = SAMPLE_W + 1;
  localparam int FIFO_DEPTH = 4;

  typedef struct packed {
    logic overflow_flag;
    logic [SAMPLE_W-1:0] sample_bits;
  } sample_s;

  // serial configuration frame
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_LAST = 5'h0F;
  localparam logic [4:0] ADDR_LAST = 5'h07;
  localparam logic [4:0] FRAME_END = 5'h10;
  localparam logic [4:0] READ_SHIFT_FROM = 5'h09;

  // register offsets
  localparam logic [6:0] RESET_OFFSET = 7'h00;
  localparam logic [6:0] FORMAT_OFFSET = 7'h04;

  // field positions
  localparam int SOFT_RESET_BIT = 7;
  localparam int TEST_PATTERN_LSB = 3;
  localparam int ALT_POLARITY_BIT = 2;
  localparam int SCRAMBLE_BIT = 1;
  localparam int SIGNED_BIT = 0;
  localparam logic [7:0] FORMAT_RESET = 8'h00;
  localparam logic [7:0] FORMAT_USED_MASK = 8'h3F;

  // test pattern codes
  localparam logic [2:0] TP_OFF = 3'h0;
  localparam logic [2:0] TP_ZEROS = 3'h1;
  localparam logic [2:0] TP_ONES = 3'h3;
  localparam logic [2:0] TP_CHECKER = 3'h5;
  localparam logic [2:0] TP_TOGGLE = 3'h7;
  localparam logic [WORD_W-1:0] CHECKER_A = 15'h5555;
  localparam logic [WORD_W-1:0] CHECKER_B = 15'h2AAA;
  localparam logic [WORD_W-1:0] ODD_BITS = 15'h2AAA;
endpackage

//--- verification/output_format_assertions.sv
// concurrent checks on the output format block ports
module output_format_assertions (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cs_n,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire fmt_pkg::sample_s out_word
);
  timeunit 1ns;
  timeprecision 1ns;
  // words held inside the path: fifo plus output register
  logic [2:0] occ;
  logic [2:0] next_occ;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  always_comb next_occ = occ + 3'(in_valid && in_ready && ce)
    - 3'(out_valid && out_ready && ce);
  always_ff @(posedge sys_clk or posedge rst)
    if (rst) occ <= '0;
    else occ <= next_occ;
  a_hold_stall: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
    else $error("word moved while stalled");
  a_freeze_ce: assert property (!ce |=> $stable(out_valid) && $stable(out_word))
    else $error("state moved with ce low");
  a_valid_within: assert property (in_valid && in_ready && ce |-> ##[1:8] out_valid)
    else $error("accepted word never shown");
  a_room_ready: assert property (occ <= 3'h3 |-> in_ready)
    else $error("refused with room left");
  a_full_refuse: assert property (occ == 3'h5 |-> !in_ready)
    else $error("accepted while full");
  a_sdo_low_only: assert property (sdo_oe |-> !sdo_o)
    else $error("sdo driven high");
  a_sdo_release: assert property (cs_n [*5] |-> !sdo_oe)
    else $error("sdo held outside frame");
  a_sdo_in_frame: assert property ($rose(sdo_oe) |-> !cs_n)
    else $error("sdo pulled low outside frame");
  a_reset_quiet: assert property ($fell(rst) |-> !out_valid && in_ready)
    else $error("path not empty after reset");
endmodule
////////////////////////////////
bind output_format output_format_assertions chk (.sys_clk, .rst, .ce, .cs_n, .sdo_o, .sdo_oe,
  .in_valid, .in_ready, .out_valid, .out_ready, .out_word);

//--- verification/sample_sink.sv
// receiver model that takes formatted words, stalling on request
module sample_sink (
  input wire logic sys_clk,
  input wire logic ce,
  input wire logic stall,
  input wire logic out_valid,
  input wire fmt_pkg::sample_s out_word,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  import fmt_pkg::*;
  sample_s got[$];
  assign out_ready = !stall;
  always @(posedge sys_clk) if (ce && out_valid && out_ready) got.push_back(out_word);
endmodule

//--- verification/tb_top.sv
// self-checking bench for the output format block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fmt_pkg::*;
  logic sys_clk = 0, rst = 1, ce = 1, cs_n = 1, sck = 0, sdi = 0, in_valid = 0, stall = 0;
  logic sdo_o, sdo_oe, in_ready, out_valid, out_ready;
  logic [7:0] q;
  sample_s in_word = '0;
  sample_s out_word;
  sample_s exp_q[$];
  int num_errors = 0, tests_run = 0, cyc = 0, nout = 0;
  logic [7:0] cfgs[11] = '{8'h00, 8'h08, 8'h18, 8'h28, 8'h38, 8'h01, 8'h02, 8'h04,
    8'h05, 8'h07, 8'h06};
  wire sdo = sdo_oe ? sdo_o : 1'b1;
  always #10 sys_clk = ~sys_clk;
  output_format uut (.sys_clk, .rst, .ce, .cs_n, .sck, .sdi, .sdo_o, .sdo_oe, .in_valid,
    .in_ready, .in_word, .out_valid, .out_ready, .out_word);
  sample_sink sink (.sys_clk, .ce, .stall, .out_valid, .out_word, .out_ready);
  ////////////////////////////////
  task tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", s, e, g);
      num_errors++;
    end
  endtask
  task spi(input logic rw, input logic [6:0] a, input logic [7:0] d);
    logic [15:0] w;
    w = {rw, a, d};
    cs_n = 0;
    for (int i = 15; i >= 0; i--) begin
      sdi = w[i];
      tick(5);
      if (i < 8) q[i] = sdo;
      sck = 1;
      tick(5);
      sck = 0;
    end
    tick(5);
    cs_n = 1;
    tick(5);
  endtask
  task rd(input logic [6:0] a, input logic [7:0] e, input string s);
    spi(1, a, 8'h00);
    chk(s, {8'h00, e}, {8'h00, q});
  endtask
  function sample_s fmt(input logic [7:0] c, input sample_s w, input logic ph);
    sample_s v;
    v = w;
    case (c[5:3])
      TP_ZEROS: v = '0;
      TP_ONES: v = '1;
      TP_CHECKER: v = ph ? 15'h2AAA : 15'h5555;
      TP_TOGGLE: v = ph ? '1 : '0;
      default: begin
        if (c[0] && !c[2]) v.sample_bits[13] = !v.sample_bits[13];
        if (c[1]) v.sample_bits[13:1] ^= {13{v.sample_bits[0]}};
        if (c[2]) v ^= 15'h2AAA;
      end
    endcase
    return v;
  endfunction
  task send(input sample_s w, input logic [7:0] c);
    in_valid = 1;
    in_word = w;
    while (in_ready !== 1'b1) tick(1);
    tick(1);
    exp_q.push_back(fmt(c, w, nout[0]));
    nout++;
  endtask
  task drain;
    in_valid = 0;
    while (sink.got.size() < exp_q.size()) tick(1);
    while (exp_q.size() > 0) chk("out_word", {1'b0, exp_q.pop_front()}, {1'b0, sink.got.pop_front()});
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    tick(3);
    rst = 0;
    tick(3);
    rd(FORMAT_OFFSET, FORMAT_RESET, "format reset value");
    rd(7'h11, 8'h00, "unmapped read");
    foreach (cfgs[i]) begin
      spi(0, FORMAT_OFFSET, cfgs[i]);
      rd(FORMAT_OFFSET, cfgs[i], "format readback");
      send(15'h2AB7, cfgs[i]);
      send(15'h4C01, cfgs[i]);
      drain();
    end
    spi(0, FORMAT_OFFSET, 8'hC2);
    rd(FORMAT_OFFSET, 8'h02, "unused bits");
    spi(0, RESET_OFFSET, 8'h80);
    rd(FORMAT_OFFSET, 8'h00, "soft reset");
    rd(RESET_OFFSET, 8'h00, "reset register");
    stall = 1;
    for (int k = 0; k < 5; k++) send(15'(k * 15'h0F3 + 1), 8'h00);
    tick(2);
    chk("in_ready full", 16'h0000, {15'h0000, in_ready});
    in_valid = 0;
    ce = 0;
    stall = 0;
    tick(4);
    chk("frozen take", 16'h0000, 16'(sink.got.size()));
    ce = 1;
    drain();
    tally_and_finish();
  end
endmodule
